/* File: rtl/cp_pkg.sv */
// Shared constants, address map and frame sizing for the control port link
package cp_pkg;
	// ----------------------------------------------------------------
	// Link framing
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h34; // Chip address, arbitrary value
	localparam int ADDR_W = 12;
	localparam int WORD_W = 40;
	localparam logic [5:0] HDR_BITS = 6'h18;
	localparam int CLK_NS = 40;
	localparam int LINK_HALF_NS = 320;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIV_W = 5;
	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [11:0] PROG_BASE = 12'h0400;
	localparam logic [11:0] REG_BASE = 12'h0800;
	localparam logic [11:0] PIN_LEVEL_ADDR = 12'h0808;
	localparam logic [11:0] SAFE_DATA_ADDR = 12'h0810;
	localparam logic [11:0] SAFE_ADDR_ADDR = 12'h0815;
	localparam logic [11:0] SAFE_END_ADDR = 12'h081A;
	localparam logic [11:0] CAPTURE0_ADDR = 12'h081A;
	localparam logic [11:0] CAPTURE1_ADDR = 12'h081B;
	localparam logic [11:0] CORE_CTRL_ADDR = 12'h081C;
	localparam logic [11:0] BYTE_REG_ADDR = 12'h081F;
	localparam logic [11:0] PIN_CFG_LOW_ADDR = 12'h0820;
	localparam logic [11:0] PIN_CFG_HIGH_ADDR = 12'h0821;
	localparam int RAM_AW = 10;
	localparam int RAM_DEPTH = 1024;
	// ----------------------------------------------------------------
	// Fields
	// ----------------------------------------------------------------
	localparam int PARAM_W = 28;
	localparam int CAPTURE_W = 24;
	localparam int CAP_SET_W = 13;
	localparam int PIN_N = 12;
	localparam int PINS_PER_CFG = 6;
	localparam int CFG_FIELD_W = 4;
	localparam int CFG_W = 24;
	localparam int CFG_INV_BIT = 3;
	localparam logic [2:0] FN_GPIO_OUT = 3'h2;
	localparam logic [2:0] FN_OPEN_DRAIN = 3'h3;
	localparam int CORE_PIN_WRITE_BIT = 7;
	localparam int CORE_DAC_ON_BIT = 3;
	localparam int CORE_RUN_BIT = 2;
	localparam logic [1:0] LEN_512 = 2'h1;
	localparam logic [1:0] LEN_256 = 2'h2;
	localparam logic [10:0] STEPS_1024 = 11'h400;
	localparam logic [10:0] STEPS_512 = 11'h200;
	localparam logic [10:0] STEPS_256 = 11'h100;

	// Data bytes that follow the header for one location
	function automatic logic [2:0] dataBytes(input logic [11:0] a, input logic rd);
		if (a < PROG_BASE) dataBytes = 3'h4;
		else if (a < REG_BASE) dataBytes = 3'h5;
		else if (a >= SAFE_DATA_ADDR && a < SAFE_ADDR_ADDR) dataBytes = 3'h5;
		else if (a == CAPTURE0_ADDR || a == CAPTURE1_ADDR) dataBytes = rd ? 3'h3 : 3'h2;
		else if (a == PIN_CFG_LOW_ADDR || a == PIN_CFG_HIGH_ADDR) dataBytes = 3'h3;
		else if (a == BYTE_REG_ADDR) dataBytes = 3'h1;
		else dataBytes = 3'h2;
	endfunction

	// Meaningful bits of one location; the rest is zero padding
	function automatic logic [5:0] fieldBits(input logic [11:0] a, input logic rd);
		if (a < PROG_BASE) fieldBits = 6'h1C;
		else if (a < REG_BASE) fieldBits = 6'h28;
		else if (a >= SAFE_DATA_ADDR && a < SAFE_ADDR_ADDR) fieldBits = 6'h1C;
		else if (a >= SAFE_ADDR_ADDR && a < SAFE_END_ADDR) fieldBits = 6'h0A;
		else if (a == CAPTURE0_ADDR || a == CAPTURE1_ADDR) fieldBits = rd ? 6'h18 : 6'h0D;
		else if (a == PIN_CFG_LOW_ADDR || a == PIN_CFG_HIGH_ADDR) fieldBits = 6'h18;
		else if (a == BYTE_REG_ADDR) fieldBits = 6'h08;
		else if (a == PIN_LEVEL_ADDR) fieldBits = 6'h0C;
		else fieldBits = 6'h10;
	endfunction

	function automatic logic [39:0] fieldMask(input logic [11:0] a, input logic rd);
		fieldMask = ~(40'hFF_FFFF_FFFF << fieldBits(a, rd));
	endfunction

	// Move an n-byte word to the top so it leaves MSB first
	function automatic logic [39:0] alignTop(input logic [39:0] w, input logic [2:0] n);
		alignTop = w << {3'h5 - n, 3'h0};
	endfunction
endpackage

/* File: rtl/ctrl_link_if.sv */
// Four-wire serial control link between host and device
`timescale 1ns/1ps
interface ctrl_link_if;
	logic spiLatchSelect_n;
	logic linkClk;
	logic hostData;
	logic deviceData;
	modport device (input spiLatchSelect_n, input linkClk, input hostData, output deviceData);
	modport host (output spiLatchSelect_n, output linkClk, output hostData, input deviceData);
endinterface

/* File: rtl/ctrl_port_host.sv */
// Host end: builds command frames and drives the link clock
`timescale 1ns/1ps
module ctrl_port_host (
	input wire logic clk,
	input wire logic rst,
	ctrl_link_if.host lnk,
	input wire logic cmdValid,
	input wire logic cmdRead,
	input wire logic [11:0] cmdAddr,
	input wire logic [7:0] cmdWords,
	input wire logic [39:0] wrWord,
	output logic cmdReady,
	output logic wrTake,
	output logic rdValid,
	output logic [39:0] rdWord
);
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_SHIFT = 2'b01, H_GAP = 2'b10} hstate_e;
	localparam logic [4:0] HALF_LAST = 5'(cp_pkg::LINK_HALF_CYC - 1);

	hstate_e st_q, st_d;
	logic [4:0] div_q, div_d;
	logic linkClk_q, linkClk_d, latch_q, latch_d, data_q, data_d, rd_q, rd_d, hdr_q, hdr_d;
	logic [39:0] tx_q, tx_d, rx_q, rx_d, rdWord_d;
	logic [5:0] bitsLeft_q, bitsLeft_d;
	logic [7:0] words_q, words_d;
	logic [11:0] addr_q, addr_d, nxtAddr;
	logic [2:0] nxtBytes;
	logic [1:0] devSync_q;
	logic wrTake_d, rdValid_d;

	assign lnk.spiLatchSelect_n = latch_q;
	assign lnk.linkClk = linkClk_q;
	assign lnk.hostData = data_q;

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		div_d = div_q;
		linkClk_d = linkClk_q;
		latch_d = latch_q;
		rd_d = rd_q;
		hdr_d = hdr_q;
		tx_d = tx_q;
		rx_d = rx_q;
		bitsLeft_d = bitsLeft_q;
		words_d = words_q;
		addr_d = addr_q;
		rdWord_d = rdWord;
		wrTake_d = 1'b0;
		rdValid_d = 1'b0;
		nxtAddr = hdr_q ? addr_q : addr_q + 12'h001;
		nxtBytes = cp_pkg::dataBytes(nxtAddr, rd_q);
		case (st_q)
			H_IDLE: begin
				if (cmdValid) begin
					tx_d = {cp_pkg::DEV_ADDR, cmdRead, 4'h0, cmdAddr, 16'h0000};
					latch_d = 1'b0;
					bitsLeft_d = cp_pkg::HDR_BITS;
					words_d = cmdWords;
					addr_d = cmdAddr;
					rd_d = cmdRead;
					hdr_d = 1'b1;
					div_d = '0;
					st_d = H_SHIFT;
				end
			end
			H_SHIFT: begin
				div_d = div_q + 5'h01;
				if (div_q == HALF_LAST) begin
					div_d = '0;
					linkClk_d = ~linkClk_q;
					if (!linkClk_q) begin
						rx_d = {rx_q[38:0], devSync_q[1]};
					end else begin
						tx_d = {tx_q[38:0], 1'b0};
						bitsLeft_d = bitsLeft_q - 6'h01;
						if (bitsLeft_q == 6'h01) begin
							if (!hdr_q && rd_q) begin
								rdWord_d = rx_q & cp_pkg::fieldMask(addr_q, 1'b1);
								rdValid_d = 1'b1;
							end
							if (words_q == 8'h00) begin
								latch_d = 1'b1;
								st_d = H_GAP;
							end else begin
								words_d = words_q - 8'h01;
								hdr_d = 1'b0;
								addr_d = nxtAddr;
								bitsLeft_d = {nxtBytes, 3'h0};
								rx_d = '0;
								wrTake_d = ~rd_q;
								tx_d = rd_q ? '0 : cp_pkg::alignTop(wrWord
									& cp_pkg::fieldMask(nxtAddr, 1'b0), nxtBytes);
							end
						end
					end
				end
			end
			H_GAP: begin
				div_d = div_q + 5'h01;
				if (div_q == HALF_LAST) begin
					div_d = '0;
					st_d = H_IDLE;
				end
			end
			default: st_d = H_IDLE;
		endcase
		data_d = tx_d[39];
	end

	// Registers and device data synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= H_IDLE;
			div_q <= '0;
			linkClk_q <= 1'b0;
			latch_q <= 1'b1;
			data_q <= 1'b0;
			rd_q <= 1'b0;
			hdr_q <= 1'b0;
			tx_q <= '0;
			rx_q <= '0;
			bitsLeft_q <= '0;
			words_q <= '0;
			addr_q <= '0;
			devSync_q <= '0;
			cmdReady <= 1'b1;
			wrTake <= 1'b0;
			rdValid <= 1'b0;
			rdWord <= '0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			linkClk_q <= linkClk_d;
			latch_q <= latch_d;
			data_q <= data_d;
			rd_q <= rd_d;
			hdr_q <= hdr_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			bitsLeft_q <= bitsLeft_d;
			words_q <= words_d;
			addr_q <= addr_d;
			devSync_q <= {devSync_q[0], lnk.deviceData};
			cmdReady <= (st_d == H_IDLE);
			wrTake <= wrTake_d;
			rdValid <= rdValid_d;
			rdWord <= rdWord_d;
		end
	end
endmodule

/* File: rtl/ctrl_port_device.sv */
// Device end: frame decoder, register file, RAMs and multipurpose pins
`timescale 1ns/1ps
module ctrl_port_device (
	input wire logic clk,
	input wire logic rst,
	ctrl_link_if.device lnk,
	input wire logic [11:0] pinIn,
	input wire logic [23:0] captureWord,
	output logic [11:0] pinOut,
	output logic [11:0] pinOe_n,
	output logic dacMute,
	output logic procClear,
	output logic [10:0] programSteps
);
	typedef enum logic [1:0] {IDLE = 2'b00, HDR = 2'b01, DATA = 2'b10, SKIP = 2'b11} state_e;

	state_e st_q, st_d;
	logic [2:0] clkSync_q;
	logic [1:0] latchSync_q, dataSync_q;
	logic [11:0] pinSync1_q, pinSync2_q, invert;
	logic rise, fall, rd_q, rd_d, miso_q, miso_d, wrEn;
	logic [2:0] bitCnt_q, bitCnt_d, byteCnt_q, byteCnt_d, nBytes, rdBytes;
	logic [1:0] hdrCnt_q, hdrCnt_d;
	logic [39:0] rxSh_q, rxSh_d, txSh_q, txSh_d, rxNext, wrWord, rdWord;
	logic [11:0] addr_q, addr_d, rdAddr;
	logic [15:0] core_q, core_d;
	logic [11:0] level_q, level_d;
	logic [23:0] cfgLow_q, cfgLow_d, cfgHigh_q, cfgHigh_d;
	logic [7:0] byteReg_q, byteReg_d;
	logic [27:0] paramRam [cp_pkg::RAM_DEPTH];
	logic [39:0] progRam [cp_pkg::RAM_DEPTH];

	assign lnk.deviceData = miso_q;
	assign rise = clkSync_q[1] & ~clkSync_q[2];
	assign fall = ~clkSync_q[1] & clkSync_q[2];
	assign rxNext = {rxSh_q[38:0], dataSync_q[1]};

	// ----------------------------------------------------------------
	// Link synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			clkSync_q <= '0;
			latchSync_q <= 2'b11;
			dataSync_q <= '0;
			pinSync1_q <= '0;
			pinSync2_q <= '0;
		end else begin
			clkSync_q <= {clkSync_q[1:0], lnk.linkClk};
			latchSync_q <= {latchSync_q[0], lnk.spiLatchSelect_n};
			dataSync_q <= {dataSync_q[0], lnk.hostData};
			pinSync1_q <= pinIn;
			pinSync2_q <= pinSync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Read data for the location about to be sent
	// ----------------------------------------------------------------
	always_comb begin
		rdAddr = (st_q == HDR) ? {addr_q[11:8], rxNext[7:0]} : addr_q + 12'h001;
		rdBytes = cp_pkg::dataBytes(rdAddr, 1'b1);
		rdWord = '0;
		if (rdAddr < cp_pkg::PROG_BASE) begin
			rdWord = 40'(paramRam[rdAddr[cp_pkg::RAM_AW-1:0]]);
		end else if (rdAddr < cp_pkg::REG_BASE) begin
			rdWord = progRam[rdAddr[cp_pkg::RAM_AW-1:0]];
		end else begin
			case (rdAddr)
				cp_pkg::PIN_LEVEL_ADDR: rdWord = core_q[cp_pkg::CORE_PIN_WRITE_BIT]
					? 40'(level_q) : '0;
				cp_pkg::CAPTURE0_ADDR, cp_pkg::CAPTURE1_ADDR: rdWord = 40'(captureWord);
				cp_pkg::CORE_CTRL_ADDR: rdWord = 40'(core_q);
				cp_pkg::BYTE_REG_ADDR: rdWord = 40'(byteReg_q);
				cp_pkg::PIN_CFG_LOW_ADDR: rdWord = 40'(cfgLow_q);
				cp_pkg::PIN_CFG_HIGH_ADDR: rdWord = 40'(cfgHigh_q);
				default: rdWord = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Frame parser
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		bitCnt_d = bitCnt_q;
		byteCnt_d = byteCnt_q;
		hdrCnt_d = hdrCnt_q;
		rxSh_d = rxSh_q;
		txSh_d = txSh_q;
		addr_d = addr_q;
		rd_d = rd_q;
		miso_d = miso_q;
		wrEn = 1'b0;
		nBytes = cp_pkg::dataBytes(addr_q, rd_q);
		if (latchSync_q[1]) begin
			st_d = IDLE;
			bitCnt_d = '0;
			byteCnt_d = '0;
			hdrCnt_d = '0;
			miso_d = 1'b0;
		end else begin
			if (st_q == IDLE) st_d = HDR;
			if (fall && st_q == DATA && rd_q) begin
				miso_d = txSh_q[39];
				txSh_d = {txSh_q[38:0], 1'b0};
			end
			if (rise && st_q != IDLE) begin
				rxSh_d = rxNext;
				bitCnt_d = bitCnt_q + 3'h1;
				if (bitCnt_q == 3'h7) begin
					case (st_q)
						HDR: begin
							hdrCnt_d = hdrCnt_q + 2'h1;
							if (hdrCnt_q == 2'h0) begin
								rd_d = rxNext[0];
								if (rxNext[7:1] != cp_pkg::DEV_ADDR) st_d = SKIP;
							end else if (hdrCnt_q == 2'h1) begin
								addr_d[11:8] = rxNext[3:0];
							end else begin
								addr_d[7:0] = rxNext[7:0];
								byteCnt_d = '0;
								st_d = DATA;
								txSh_d = cp_pkg::alignTop(rdWord, rdBytes);
							end
						end
						DATA: begin
							byteCnt_d = byteCnt_q + 3'h1;
							if (byteCnt_q + 3'h1 == nBytes) begin
								byteCnt_d = '0;
								wrEn = ~rd_q;
								addr_d = addr_q + 12'h001;
								txSh_d = cp_pkg::alignTop(rdWord, rdBytes);
							end
						end
						default: st_d = st_q;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_comb begin
		core_d = core_q;
		level_d = level_q;
		cfgLow_d = cfgLow_q;
		cfgHigh_d = cfgHigh_q;
		byteReg_d = byteReg_q;
		wrWord = rxNext & cp_pkg::fieldMask(addr_q, 1'b0);
		if (!core_q[cp_pkg::CORE_PIN_WRITE_BIT]) level_d = pinSync2_q ^ invert;
		if (wrEn) begin
			case (addr_q)
				cp_pkg::PIN_LEVEL_ADDR: begin
					if (core_q[cp_pkg::CORE_PIN_WRITE_BIT]) level_d = wrWord[11:0];
				end
				cp_pkg::CAPTURE0_ADDR: core_d = core_q; // Setup sized only
				cp_pkg::CORE_CTRL_ADDR: core_d = wrWord[15:0];
				cp_pkg::BYTE_REG_ADDR: byteReg_d = wrWord[7:0];
				cp_pkg::PIN_CFG_LOW_ADDR: cfgLow_d = wrWord[23:0];
				cp_pkg::PIN_CFG_HIGH_ADDR: cfgHigh_d = wrWord[23:0];
				default: core_d = core_q; // Atomic-load slots sized, not stored
			endcase
		end
	end

	// Registers and core-control outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= IDLE;
			bitCnt_q <= '0;
			byteCnt_q <= '0;
			hdrCnt_q <= '0;
			rxSh_q <= '0;
			txSh_q <= '0;
			addr_q <= '0;
			rd_q <= 1'b0;
			miso_q <= 1'b0;
			core_q <= '0;
			level_q <= '0;
			cfgLow_q <= '0;
			cfgHigh_q <= '0;
			byteReg_q <= '0;
			dacMute <= 1'b1;
			procClear <= 1'b1;
			programSteps <= cp_pkg::STEPS_1024;
		end else begin
			st_q <= st_d;
			bitCnt_q <= bitCnt_d;
			byteCnt_q <= byteCnt_d;
			hdrCnt_q <= hdrCnt_d;
			rxSh_q <= rxSh_d;
			txSh_q <= txSh_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			miso_q <= miso_d;
			core_q <= core_d;
			level_q <= level_d;
			cfgLow_q <= cfgLow_d;
			cfgHigh_q <= cfgHigh_d;
			byteReg_q <= byteReg_d;
			dacMute <= ~core_d[cp_pkg::CORE_DAC_ON_BIT];
			procClear <= ~core_d[cp_pkg::CORE_RUN_BIT];
			case (core_d[1:0])
				cp_pkg::LEN_512: programSteps <= cp_pkg::STEPS_512;
				cp_pkg::LEN_256: programSteps <= cp_pkg::STEPS_256;
				default: programSteps <= cp_pkg::STEPS_1024;
			endcase
		end
	end

	// RAM write ports
	always_ff @(posedge clk) begin
		if (wrEn && addr_q < cp_pkg::PROG_BASE) begin
			paramRam[addr_q[cp_pkg::RAM_AW-1:0]] <= wrWord[27:0];
		end
		if (wrEn && addr_q >= cp_pkg::PROG_BASE && addr_q < cp_pkg::REG_BASE) begin
			progRam[addr_q[cp_pkg::RAM_AW-1:0]] <= wrWord;
		end
	end

	// ----------------------------------------------------------------
	// Multipurpose pins
	// ----------------------------------------------------------------
	for (genvar i = 0; i < cp_pkg::PIN_N; i++) begin : g_pin
		localparam int LSB = (i % cp_pkg::PINS_PER_CFG) * cp_pkg::CFG_FIELD_W;
		logic [3:0] fn;
		logic lvl;
		assign fn = (i < cp_pkg::PINS_PER_CFG) ? cfgLow_q[LSB +: 4] : cfgHigh_q[LSB +: 4];
		assign invert[i] = fn[cp_pkg::CFG_INV_BIT];
		assign lvl = level_q[i] ^ invert[i];
		always_ff @(posedge clk) begin
			if (rst) begin
				pinOut[i] <= 1'b0;
				pinOe_n[i] <= 1'b1;
			end else begin
				pinOut[i] <= lvl;
				pinOe_n[i] <= ~(fn[2:0] == cp_pkg::FN_GPIO_OUT
					|| (fn[2:0] == cp_pkg::FN_OPEN_DRAIN && !lvl));
			end
		end
	end
endmodule

/* File: bench/cp_link_sva.sv */
// Link-level checker for the serial control link between the two ends
`timescale 1ns/1ps
module cp_link_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic spiLatchSelect_n,
	input wire logic linkClk,
	input wire logic hostData,
	input wire logic deviceData
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Frame bit counter and address shifter
	// ----------------------------------------------------------------
	logic [9:0] bitCnt_q, bitCnt_d;
	logic [6:0] shift_q, shift_d;
	logic clkPrev_q;
	// Count host bits taken on link clock rises
	always_comb begin
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		if (spiLatchSelect_n) begin
			bitCnt_d = 10'h000;
		end else if (linkClk && !clkPrev_q) begin
			bitCnt_d = bitCnt_q + 10'h001;
			shift_d = {shift_q[5:0], hostData};
		end
	end
	// Register counter state
	always_ff @(posedge clk) begin
		if (rst) begin
			bitCnt_q <= 10'h000;
			shift_q <= 7'h00;
			clkPrev_q <= 1'b0;
		end else begin
			bitCnt_q <= bitCnt_d;
			shift_q <= shift_d;
			clkPrev_q <= linkClk;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence sHighPhase;
		linkClk [*8] ##1 !linkClk;
	endsequence
	sequence sLowPhase;
		!linkClk [*8];
	endsequence
	a_high_width: assert property ($rose(linkClk) |-> sHighPhase)
		else $error("link clock high phase not eight cycles");
	a_low_width: assert property ($fell(linkClk) |-> sLowPhase)
		else $error("link clock low phase too short");
	a_idle_clock: assert property (spiLatchSelect_n |-> !linkClk)
		else $error("link clock moves outside a frame");
	a_host_stable: assert property (linkClk && !spiLatchSelect_n |-> $stable(hostData))
		else $error("host data changed while link clock high");
	a_dev_stable: assert property (linkClk |-> $stable(deviceData))
		else $error("device data changed while link clock high");
	a_dev_quiet: assert property (spiLatchSelect_n [*4] |-> !deviceData)
		else $error("device data not low between frames");
	a_frame_gap: assert property ($rose(spiLatchSelect_n) |-> spiLatchSelect_n [*3])
		else $error("frames closer than three cycles");
	a_whole_bytes: assert property ($rose(spiLatchSelect_n) |->
		bitCnt_q[2:0] == 3'h0 && bitCnt_q >= 10'h018)
		else $error("frame not whole bytes with full header");
	a_chip_addr: assert property ($rose(bitCnt_q == 10'h007) |->
		shift_q == cp_pkg::DEV_ADDR)
		else $error("first seven bits are not the chip address");
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench: host and device ends joined across the link
`timescale 1ns/1ps
module tb_top;
	logic clk, rst, cmdValid, cmdRead, cmdReady, wrTake, rdValid, dacMute, procClear;
	logic [11:0] cmdAddr, pinIn, pinOut, pinOe_n;
	logic [7:0] cmdWords;
	logic [39:0] wrWord, rdWord;
	logic [23:0] captureWord;
	logic [10:0] programSteps;
	logic [39:0] wq[$];
	logic [39:0] rq[$];
	logic [39:0] mem[int];
	int badCount;
	int nCompared;
	ctrl_link_if lnkBus();
	ctrl_port_host ctrl_port_host_inst (.clk(clk), .rst(rst), .lnk(lnkBus),
		.cmdValid(cmdValid), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdWords(cmdWords),
		.wrWord(wrWord), .cmdReady(cmdReady), .wrTake(wrTake), .rdValid(rdValid),
		.rdWord(rdWord));
	ctrl_port_device ctrl_port_device_inst (.clk(clk), .rst(rst), .lnk(lnkBus),
		.pinIn(pinIn), .captureWord(captureWord), .pinOut(pinOut), .pinOe_n(pinOe_n),
		.dacMute(dacMute), .procClear(procClear), .programSteps(programSteps));
	cp_link_sva cp_link_sva_inst (.clk(clk), .rst(rst),
		.spiLatchSelect_n(lnkBus.spiLatchSelect_n), .linkClk(lnkBus.linkClk),
		.hostData(lnkBus.hostData), .deviceData(lnkBus.deviceData));
	// ----------------------------------------------------------------
	// Model and helpers
	// ----------------------------------------------------------------
	// Meaningful bits of one location
	function automatic logic [39:0] fmask(input int a);
		int b;
		if (a < 12'h400) b = 28;
		else if (a < 12'h800) b = 40;
		else if (a == 12'h808) b = 12;
		else if (a >= 12'h810 && a < 12'h815) b = 28;
		else if (a >= 12'h815 && a < 12'h81A) b = 10;
		else if (a == 12'h81A || a == 12'h81B) b = 13;
		else if (a == 12'h81F) b = 8;
		else if (a == 12'h820 || a == 12'h821) b = 24;
		else b = 16;
		fmask = (b == 40) ? 40'hFF_FFFF_FFFF : ((40'h1 << b) - 40'h1);
	endfunction
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		nCompared++;
		if (seen !== exp) begin
			badCount++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (badCount == 0 && nCompared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// One frame through the host port, words fed on each take
	task automatic xfer(input logic rd, input logic [11:0] a, input int n);
		int t;
		rq.delete();
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdRead <= rd;
		cmdAddr <= a;
		cmdWords <= 8'(n);
		wrWord <= (wq.size() > 0) ? wq[0] : 40'h0;
		@(posedge clk);
		cmdValid <= 1'b0;
		t = 0;
		do begin
			@(posedge clk);
			t++;
			if (wrTake === 1'b1 && wq.size() > 0) begin
				void'(wq.pop_front());
				wrWord <= (wq.size() > 0) ? wq[0] : 40'h0;
			end
			if (rdValid === 1'b1) rq.push_back(rdWord);
		end while (cmdReady !== 1'b1 && t < 5000);
		if (t >= 5000) check(1'b0, 1'b1);
	endtask
	task automatic wrOne(input logic [11:0] a, input logic [39:0] w);
		wq.push_back(w);
		mem[a] = w & fmask(a);
		xfer(1'b0, a, 1);
	endtask
	// Burst of random words, pad bits included
	task automatic wrRand(input logic [11:0] a, input int n);
		logic [39:0] w;
		for (int i = 0; i < n; i++) begin
			w = {8'($urandom), $urandom};
			wq.push_back(w);
			mem[a + i] = w & fmask(a + i);
		end
		xfer(1'b0, a, n);
	endtask
	task automatic rdCheck(input logic [11:0] a, input int n);
		xfer(1'b1, a, n);
		check(40'(rq.size()), 40'(n));
		for (int i = 0; i < n && i < rq.size(); i++) check(rq[i], mem[a + i]);
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		badCount++;
		complete_run();
	end
	initial begin
		logic [15:0] v;
		logic [11:0] a;
		logic [39:0] lv;
		void'($urandom(2));
		rst = 1'b1;
		cmdValid = 1'b0;
		cmdRead = 1'b0;
		cmdAddr = 12'h000;
		cmdWords = 8'h00;
		wrWord = 40'h0;
		captureWord = 24'h00_0000;
		pinIn = 12'(($urandom));
		badCount = 0;
		nCompared = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(dacMute, 1'b1);
		check(procClear, 1'b1);
		check(programSteps, 11'h400);
		check(pinOe_n, 12'hFFF);
		// Length codes 0 to 2 with mute and clear toggled
		for (int i = 0; i < 3; i++) begin
			v = 16'(i) | ((i == 1) ? 16'h0008 : 16'h0004);
			wrOne(12'h81C, 40'(v));
			check(dacMute, !v[3]);
			check(procClear, !v[2]);
			check(programSteps, (i == 0) ? 11'h400 : (i == 1) ? 11'h200 : 11'h100);
			rdCheck(12'h81C, 1);
		end
		// Burst through atomic-load and capture slots into core control
		wrRand(12'h814, 9);
		rdCheck(12'h81C, 1);
		wrRand(12'h81F, 1);
		rdCheck(12'h81F, 1);
		wrOne(12'h81C, 40'h000C);
		// Burst across the parameter to program boundary
		wrRand(12'h3FE, 3);
		rdCheck(12'h3FE, 3);
		// Random single locations in both RAMs
		for (int i = 0; i < 4; i++) begin
			a = (i[0]) ? 12'h400 + 12'($urandom % 1024) : 12'($urandom % 1024);
			wrRand(a, 1);
			rdCheck(a, 1);
		end
		// Capture readback
		lv = 40'($urandom);
		captureWord <= lv[23:0];
		mem[12'h81A] = {16'h0000, lv[23:0]};
		rdCheck(12'h81A, 1);
		// Pin functions: low pins plain output, high pins inverted output
		wrOne(12'h820, 40'h22_2222);
		wrOne(12'h821, 40'hAA_AAAA);
		rdCheck(12'h820, 2);
		wq.push_back(40'hFFFF);
		xfer(1'b0, 12'h808, 1);
		mem[12'h808] = 40'h0;
		rdCheck(12'h808, 1);
		check(pinOut, pinIn);
		wrOne(12'h81C, 40'h008C);
		lv = 40'($urandom);
		wrOne(12'h808, lv);
		check(pinOut, lv[11:0] ^ 12'hFC0);
		check(pinOe_n, 12'h000);
		rdCheck(12'h808, 1);
		@(posedge clk);
		pinIn <= ~pinIn;
		repeat (10) @(posedge clk);
		check(pinOut, lv[11:0] ^ 12'hFC0);
		complete_run();
	end
endmodule
